// file: rtl/psb_map.svh
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH

// Word configuration codes for the memory core.
`define PSB_CFG_X18 2'h0
`define PSB_CFG_X32 2'h1
`define PSB_CFG_X36 2'h2

// Core geometry per configuration.
`define PSB_X18_ADDR_W 20
`define PSB_X32_ADDR_W 19
`define PSB_LANE_W 8
`define PSB_LANES_MAX 4
`define PSB_BURST_W 2

// Depth of the write buffer between the pins and the core.
`define PSB_FIFO_DEPTH 32

`endif

// file: rtl/psb_pkg.sv
package psb_pkg;

    // Configuration of the memory core word.
    typedef enum logic [1:0] {
        PSB_X18 = 2'b00,
        PSB_X32 = 2'b01,
        PSB_X36 = 2'b10
    } psb_cfg_type;

    // Access state of the port.
    typedef enum logic [1:0] {
        PSB_IDLE = 2'b00,
        PSB_READ = 2'b01,
        PSB_WRITE = 2'b10,
        PSB_SLEEP = 2'b11
    } psb_state_type;

    // One buffered write: address, data with parity and lane mask.
    typedef struct packed {
        logic [19:0] addr;
        logic [35:0] data;
        logic [3:0] lanes;
    } psb_wr_type;

endpackage

// file: rtl/psb_fifo.sv
`timescale 1ns/1ps

module psb_fifo #(
    parameter int WIDTH = 60,
    parameter int DEPTH = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Handshakes on both sides; full and empty come from the count.
    assign o_in_ready = (count_r != DEPTH[AW:0]);
    assign o_out_valid = (count_r != '0);
    assign o_out_data = mem[rd_ptr_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Storage array write port.
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
            end
            if (pop) begin
                rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
            end
            count_r <= (AW + 1)'(count_r + push - pop);
        end
    end
endmodule

// file: rtl/psb_port.sv
`timescale 1ns/1ps
`include "psb_map.svh"

// What this block does
// - All synchronous inputs are registered on the rising clock edge.
// - A two bit burst counter supplies the low address bits.
// - Core is 1M x 18, or 512K x 32 or x36 words.
// - Three selects: primary low, second high, third low.
// - Output enable and standby request are also registered, two stages deep.
// - A static select picks interleaved or linear burst order.
// - Data pins are driven only while output enable is asserted.
// - Write and read data share one bidirectional data bus.
// - Writes cover one to two lanes (x18) or one to four lanes.
// - Either address strobe loads a new starting address.
// - Counter advances only on cycles with burst advance asserted.
// - Write address and controls are held on chip; writes self-time.
// - On x18, strobes a and b gate lanes a and b with parity.
// - On x32/x36, strobes a to d gate matching lanes; on x36 also parity.
// - All-bytes write strobe low writes every lane.
// - Parity storage exists only in x18 and x36 parts.
// - Outputs stay enabled one extra cycle after a deselect.
// - A snooze standby state reduces power.
// - Processor strobe is ignored while primary select is high.
// - Controller strobe with primary select high deselects to idle.
// - Low order select gives linear order, high gives interleaved.
module psb_port #(
    parameter psb_pkg::psb_cfg_type CFG = psb_pkg::PSB_X36,
    parameter int ADDR_W = `PSB_X32_ADDR_W,
    parameter int FIFO_DEPTH = `PSB_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [19:0] i_addr,
    input wire logic i_chip_select_n,
    input wire logic i_second_select_high,
    input wire logic i_third_select_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_burst_advance_n,
    input wire logic [3:0] i_byte_lane_write_n,
    input wire logic i_lane_write_gate_n,
    input wire logic i_all_bytes_write_n,
    input wire logic i_output_enable_n,
    input wire logic i_standby_request,
    input wire logic i_linear_order_select_n,
    input wire logic [35:0] i_data,
    output logic [35:0] o_data,
    output logic [35:0] o_data_oe,
    output logic o_standby_active
);
    localparam int WORDS = 1 << ADDR_W;
    localparam int NLANES = (CFG == psb_pkg::PSB_X18) ? 2 : 4;
    localparam int WR_W = $bits(psb_pkg::psb_wr_type);

    ////////////////////////////////////////////////////////////////////
    // Input pins, two flip-flops deep before any logic reads them.

    logic [19:0] addr_m, addr_s;
    logic ce_n_m, ce_n_s, ce2_m, ce2_s, ce2n_m, ce2n_s;
    logic controller_addr_strobe_n_m, controller_addr_strobe_n_s, processor_addr_strobe_n_m, processor_addr_strobe_n_s, adv_m, adv_s;
    logic [3:0] bw_m, bw_s;
    logic bwe_m, bwe_s, gw_m, gw_s;
    logic oe_m, oe_s, zz_m, zz_s, lbo_m, lbo_s;
    logic [35:0] din_m, din_s;

    // Synchronous inputs captured on the rising edge.
    always_ff @(posedge i_clk_sys) begin
        addr_m <= i_addr;
        ce_n_m <= i_chip_select_n;
        ce2_m <= i_second_select_high;
        ce2n_m <= i_third_select_n;
        controller_addr_strobe_n_m <= i_controller_addr_strobe_n;
        processor_addr_strobe_n_m <= i_processor_addr_strobe_n;
        adv_m <= i_burst_advance_n;
        bw_m <= i_byte_lane_write_n;
        bwe_m <= i_lane_write_gate_n;
        gw_m <= i_all_bytes_write_n;
        din_m <= i_data;
        addr_s <= addr_m;
        ce_n_s <= ce_n_m;
        ce2_s <= ce2_m;
        ce2n_s <= ce2n_m;
        controller_addr_strobe_n_s <= controller_addr_strobe_n_m;
        processor_addr_strobe_n_s <= processor_addr_strobe_n_m;
        adv_s <= adv_m;
        bw_s <= bw_m;
        bwe_s <= bwe_m;
        gw_s <= gw_m;
        din_s <= din_m;
    end

    // Levels from outside that act without a clock sample in the core;
    // they still pass two stages, so their effect trails by two cycles.
    always_ff @(posedge i_clk_sys) begin
        oe_m <= i_output_enable_n;
        zz_m <= i_standby_request;
        lbo_m <= i_linear_order_select_n;
        oe_s <= oe_m;
        zz_s <= zz_m;
        lbo_s <= lbo_m;
    end

    ////////////////////////////////////////////////////////////////////
    // Access decode.

    logic selected;
    logic processor_addr_strobe_n_go, controller_addr_strobe_n_go, controller_addr_strobe_n_down, load, any_write;
    logic [3:0] lanes;

    // All three selects must agree for a new access.
    assign selected = !ce_n_s && ce2_s && !ce2n_s;
    assign processor_addr_strobe_n_go = !processor_addr_strobe_n_s && !ce_n_s;
    assign controller_addr_strobe_n_go = !controller_addr_strobe_n_s && processor_addr_strobe_n_s;
    assign controller_addr_strobe_n_down = controller_addr_strobe_n_go && ce_n_s;
    assign load = (processor_addr_strobe_n_go || controller_addr_strobe_n_go) && !zz_s;

    // Lane selection; the all-bytes strobe overrides the lane strobes.
    always_comb begin
        lanes = '0;
        if (!gw_s) begin
            lanes = 4'hf;
        end else if (!bwe_s) begin
            lanes = ~bw_s;
        end
        if (NLANES == 2) begin
            lanes[3:2] = 2'b00;
        end
    end
    assign any_write = (lanes != 4'h0);

    ////////////////////////////////////////////////////////////////////
    // Burst address and access state.

    psb_pkg::psb_state_type state_r;
    logic [19:0] base_r;
    logic [1:0] start_r, cnt_r, low_bits;
    logic first_r;

    // Interleaved XORs the count into the start; linear adds.
    assign low_bits = lbo_s ? (start_r ^ cnt_r)
                            : 2'(start_r + cnt_r);

    // Address loading and counting.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            base_r <= '0;
            start_r <= '0;
            cnt_r <= '0;
            first_r <= 1'b0;
        end else if (load) begin
            base_r <= addr_s;
            start_r <= addr_s[1:0];
            cnt_r <= '0;
            first_r <= processor_addr_strobe_n_go;
        end else if (!zz_s && !adv_s && state_r != psb_pkg::PSB_IDLE) begin
            cnt_r <= 2'(cnt_r + 1'b1);
            first_r <= 1'b0;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Processor strobe on a selected part reads unless in or just leaving standby; later write cycles may follow.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            state_r <= psb_pkg::PSB_IDLE;
        end else begin
            case (state_r)
                psb_pkg::PSB_SLEEP: begin
                    if (!zz_s) begin
                        state_r <= psb_pkg::PSB_IDLE;
                    end
                end
                default: begin
                    if (zz_s) begin
                        state_r <= psb_pkg::PSB_SLEEP;
                    end else if (load && (!selected || controller_addr_strobe_n_down)) begin
                        state_r <= psb_pkg::PSB_IDLE;
                    end else if (processor_addr_strobe_n_go) begin
                        state_r <= psb_pkg::PSB_READ;
                    end else if (controller_addr_strobe_n_go) begin
                        state_r <= any_write ? psb_pkg::PSB_WRITE
                                             : psb_pkg::PSB_READ;
                    end else if (state_r != psb_pkg::PSB_IDLE && any_write) begin
                        state_r <= psb_pkg::PSB_WRITE;
                    end else if (state_r == psb_pkg::PSB_WRITE) begin
                        // Dropping to idle keeps the drivers off the bus.
                        state_r <= psb_pkg::PSB_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write buffer and core.

    logic [ADDR_W-1:0] cur_addr;
    psb_pkg::psb_wr_type wr_in, wr_out;
    logic wr_valid, wr_ready, fifo_ready, wr_take;
    logic [WR_W-1:0] wr_out_bits;

    assign cur_addr = ADDR_W'({base_r[19:2], low_bits});

    // A write is queued from the cycle after a controller strobe took its address, or the second cycle after a processor strobe.
    assign wr_valid = !zz_s && (state_r != psb_pkg::PSB_IDLE)
                      && (state_r != psb_pkg::PSB_SLEEP) && any_write
                      && !load && !first_r;
    always_comb begin
        wr_in.addr = 20'(cur_addr);
        wr_in.data = din_s;
        wr_in.lanes = lanes;
    end

    // Address, data and lanes are held on chip until written.
    psb_fifo #(
        .WIDTH(WR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_in_valid(wr_valid),
        .o_in_ready(fifo_ready),
        .i_in_data(wr_in),
        .o_out_valid(wr_take),
        .i_out_ready(wr_ready),
        .o_out_data(wr_out_bits)
    );
    assign wr_out = psb_pkg::psb_wr_type'(wr_out_bits);

    // The core takes one buffered write per cycle, paused in standby.
    assign wr_ready = !zz_s;

    logic [`PSB_LANE_W:0] core [NLANES][WORDS];
    logic [35:0] rd_word;

    // One array per lane, each with its own write gate.
    for (genvar g = 0; g < NLANES; g++) begin : g_lane
        always_ff @(posedge i_clk_sys) begin
            if (wr_take && wr_ready && wr_out.lanes[g]) begin
                core[g][ADDR_W'(wr_out.addr)] <= {
                    (CFG == psb_pkg::PSB_X32) ? 1'b0
                        : wr_out.data[32 + g],
                    wr_out.data[g*8 +: 8]};
            end
        end
        assign rd_word[g*8 +: 8] = core[g][cur_addr][7:0];
        assign rd_word[32 + g] = (CFG == psb_pkg::PSB_X32) ? 1'b0
                                 : core[g][cur_addr][8];
    end
    if (NLANES == 2) begin : g_upper
        assign rd_word[31:16] = '0;
        assign rd_word[35:34] = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // Output pipeline and pin drive.

    logic rd_live, drive_r, drive_hold_r;

    assign rd_live = (state_r == psb_pkg::PSB_READ) && !zz_s;

    // Enable pipeline keeps drivers on one cycle past a deselect.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            drive_r <= 1'b0;
            drive_hold_r <= 1'b0;
        end else begin
            drive_r <= rd_live;
            drive_hold_r <= drive_r;
        end
    end

    // Read data register and gated pin enables.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_data <= '0;
            o_data_oe <= '0;
            o_standby_active <= 1'b0;
        end else begin
            if (rd_live) begin
                o_data <= rd_word;
            end
            o_data_oe <= {36{(drive_r || drive_hold_r) && !oe_s
                             && !zz_s}};
            o_standby_active <= zz_s;
        end
    end
endmodule

// file: sim/psb_port_properties.sv
`timescale 1ns/1ps
// Pin-level checks on the burst port, seen only through its ports.
module psb_port_properties (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_chip_select_n,
    input wire logic i_second_select_high,
    input wire logic i_third_select_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_output_enable_n,
    input wire logic i_standby_request,
    input wire logic [35:0] o_data,
    input wire logic [35:0] o_data_oe,
    input wire logic o_standby_active
);
    logic sel_w;
    logic quiet_w;
    // One clock domain, so one default clock and reset.
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);
    // Selected part and a cycle with no address strobe.
    assign sel_w = !i_chip_select_n && i_second_select_high
        && !i_third_select_n;
    assign quiet_w = i_processor_addr_strobe_n && i_controller_addr_strobe_n;
    a_reset_clears: assert property (disable iff (1'b0)
        !i_rstn |=> o_data_oe == '0 && !o_standby_active)
        else $error("outputs not quiet after reset");
    a_oe_gates: assert property (i_output_enable_n [*5]
        |-> o_data_oe == '0) else $error("pins driven while disabled");
    a_lanes_whole: assert property (o_data_oe == '0 || o_data_oe == '1)
        else $error("lane drive split");
    a_read_drives: assert property ((!i_processor_addr_strobe_n && sel_w
        && !i_output_enable_n && !i_standby_request) ##1
        (!i_output_enable_n && !i_standby_request) [*6] |-> o_data_oe == '1)
        else $error("read did not drive pins");
    a_strobe_ignored: assert property (quiet_w [*4] ##1 (i_chip_select_n
        && !i_processor_addr_strobe_n && i_controller_addr_strobe_n
        && o_data_oe == '0) ##1 quiet_w [*6] |-> o_data_oe == '0)
        else $error("ignored strobe caused a read");
    a_deselect_off: assert property ((i_chip_select_n &&
        !i_controller_addr_strobe_n) ##1 quiet_w [*7] |-> o_data_oe == '0)
        else $error("deselect left pins driven");
    a_standby_enter: assert property (i_standby_request [*5]
        |-> o_standby_active) else $error("standby not entered");
    a_standby_leave: assert property (!i_standby_request [*5]
        |-> !o_standby_active) else $error("standby not left");
    a_standby_frozen: assert property (o_standby_active [*3]
        |-> $stable(o_data)) else $error("data changed in standby");
endmodule

bind psb_port psb_port_properties u_props (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_chip_select_n(i_chip_select_n),
    .i_second_select_high(i_second_select_high),
    .i_third_select_n(i_third_select_n),
    .i_controller_addr_strobe_n(i_controller_addr_strobe_n),
    .i_processor_addr_strobe_n(i_processor_addr_strobe_n),
    .i_output_enable_n(i_output_enable_n),
    .i_standby_request(i_standby_request), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_standby_active(o_standby_active));

// file: sim/psb_ctrl_model.sv
`timescale 1ns/1ps
// Bus master on the controller side; pins change at falling edges, released data at rising.
module psb_ctrl_model (
    input wire logic i_clk_sys,
    output logic [19:0] o_addr,
    output logic o_chip_select_n,
    output logic o_controller_addr_strobe_n,
    output logic o_processor_addr_strobe_n,
    output logic o_burst_advance_n,
    output logic [3:0] o_byte_lane_write_n,
    output logic o_lane_write_gate_n,
    output logic o_all_bytes_write_n,
    output logic [35:0] o_data
);
    logic drv_r;
    int cnt;
    // Start selected, with no strobe and no write control active.
    initial begin
        o_addr = '0;
        {o_chip_select_n, o_controller_addr_strobe_n} = 2'b01;
        {o_processor_addr_strobe_n, o_burst_advance_n} = 2'b11;
        {o_lane_write_gate_n, o_all_bytes_write_n} = 2'b11;
        o_byte_lane_write_n = 4'hf;
        o_data = '0;
        drv_r = 1'b0;
        cnt = 0;
    end
    // Released data lines toggle so a stale value can never match.
    always @(posedge i_clk_sys) begin
        cnt <= cnt + 1;
        if (!drv_r) o_data <= ~o_data;
    end
    // Write started by the controller strobe; advance stays high.
    task automatic write(input logic [19:0] a, input logic [35:0] d,
        input logic g_n, input logic [3:0] b_n, input logic w_n);
        @(negedge i_clk_sys);
        o_addr = a;
        o_data = d;
        drv_r = 1'b1;
        o_controller_addr_strobe_n = 1'b0;
        o_lane_write_gate_n = g_n;
        o_byte_lane_write_n = b_n;
        o_all_bytes_write_n = w_n;
        @(negedge i_clk_sys);
        o_controller_addr_strobe_n = 1'b1;
        @(negedge i_clk_sys);
        {o_lane_write_gate_n, o_all_bytes_write_n} = 2'b11;
        o_byte_lane_write_n = 4'hf;
        @(negedge i_clk_sys);
        drv_r = 1'b0;
    endtask
    // Burst read: processor strobe, then advance on each later word.
    task automatic read(input logic [19:0] a, input int n, output int t);
        @(negedge i_clk_sys);
        o_addr = a;
        o_processor_addr_strobe_n = 1'b0;
        t = cnt;
        repeat (n - 1) begin
            @(negedge i_clk_sys);
            o_processor_addr_strobe_n = 1'b1;
            o_burst_advance_n = 1'b0;
        end
        @(negedge i_clk_sys);
        {o_processor_addr_strobe_n, o_burst_advance_n} = 2'b11;
    endtask
    // One strobe with a chosen primary select level.
    task automatic strobe(input logic ctl, input logic cs_n);
        @(negedge i_clk_sys);
        o_chip_select_n = cs_n;
        if (ctl) o_controller_addr_strobe_n = 1'b0;
        else o_processor_addr_strobe_n = 1'b0;
        @(negedge i_clk_sys);
        o_chip_select_n = 1'b0;
        {o_controller_addr_strobe_n, o_processor_addr_strobe_n} = 2'b11;
    endtask
endmodule

// file: sim/test_pipelined_burst_sram_port.sv
`timescale 1ns/1ps
// Self-checking bench for the port in its 36-bit form.
module test_pipelined_burst_sram_port;
    typedef struct {
        int due;
        logic oe;
        logic [35:0] val;
    } psb_note_type;
    logic clk, rstn, oe_n, zz, lbo_n, cs_n, controller_addr_strobe_n_n, processor_addr_strobe_n_n, adv_n;
    logic gate_n, gw_n, sb;
    logic [3:0] bw_n;
    logic [19:0] addr;
    logic [35:0] ctl_d, dut_q, dut_oe, bus;
    logic [31:0] rng;
    logic [35:0] mem [logic [19:0]];
    psb_note_type exp_q [$];
    int error_cnt, n_tests;
    // Clock at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // The shared data wire: the port's drivers win where enabled.
    assign bus = (dut_oe & dut_q) | (~dut_oe & ctl_d);
    psb_ctrl_model u_ctl (.i_clk_sys(clk), .o_addr(addr),
        .o_chip_select_n(cs_n), .o_controller_addr_strobe_n(controller_addr_strobe_n_n),
        .o_processor_addr_strobe_n(processor_addr_strobe_n_n), .o_burst_advance_n(adv_n),
        .o_byte_lane_write_n(bw_n), .o_lane_write_gate_n(gate_n),
        .o_all_bytes_write_n(gw_n), .o_data(ctl_d));
    psb_port #(.CFG(psb_pkg::PSB_X36), .ADDR_W(19), .FIFO_DEPTH(32)) u_dut (
        .i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr),
        .i_chip_select_n(cs_n), .i_second_select_high(1'b1),
        .i_third_select_n(1'b0), .i_controller_addr_strobe_n(controller_addr_strobe_n_n),
        .i_processor_addr_strobe_n(processor_addr_strobe_n_n), .i_burst_advance_n(adv_n),
        .i_byte_lane_write_n(bw_n), .i_lane_write_gate_n(gate_n),
        .i_all_bytes_write_n(gw_n), .i_output_enable_n(oe_n),
        .i_standby_request(zz), .i_linear_order_select_n(lbo_n),
        .i_data(bus), .o_data(dut_q), .o_data_oe(dut_oe),
        .o_standby_active(sb));
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic logic [35:0] rw();
        logic [63:0] v;
        v = {rnd(), rnd()};
        return v[35:0];
    endfunction
    // Lane n carries data bits 8n+7..8n and parity bit 32+n.
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] d,
        logic [3:0] m);
        for (int k = 0; k < 4; k++) begin
            if (m[k]) o[8*k+:8] = d[8*k+:8];
            if (m[k]) o[32+k] = d[32+k];
        end
        return o;
    endfunction
    task automatic cmp_data(input logic [35:0] e, input logic [35:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_oe(input logic [35:0] g);
        cmp_data('1, g);
    endtask
    task automatic wr(input logic [19:0] a, input logic [35:0] d,
        input logic [3:0] m, input logic all_n);
        mem[a] = all_n ? merge(mem[a], d, m) : d;
        u_ctl.write(a, d, 1'b0, ~m, all_n);
    endtask
    task automatic rd(input logic [19:0] a, input int n);
        int t;
        logic [1:0] lo;
        u_ctl.read(a, n, t);
        for (int i = 0; i < n; i++) begin
            lo = lbo_n ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
            exp_q.push_back('{t + 4 + i, i == n - 1, mem[{a[19:2], lo}]});
        end
    endtask
    task report_and_stop();
        // A note never taken off the queue is a missed result.
        if (exp_q.size() != 0) error_cnt++;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Takes the oldest note when its cycle comes and checks the pins.
    always @(negedge clk) begin
        if (exp_q.size() > 0 && exp_q[0].due == u_ctl.cnt) begin
            cmp_data(exp_q[0].val, dut_q);
            if (exp_q[0].oe === 1'b1) cmp_oe(dut_oe);
            void'(exp_q.pop_front());
        end
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        report_and_stop();
    end
    // Writes, burst reads in both orders, deselects and standby.
    initial begin
        logic [19:0] base;
        int t;
        rng = 32'h2b3f64fe;
        {rstn, oe_n, zz, lbo_n} = 4'h0;
        error_cnt = 0;
        n_tests = 0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        base = 20'(rnd() & 32'h7fffc);
        for (int i = 0; i < 4; i++) wr(base + 20'(i), rw(), 4'h0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(base + 20'(i % 4), rw(), 4'(rnd() % 15 + 1), 1'b1);
        end
        repeat (40) @(negedge clk);
        for (int k = 0; k < 4; k++) begin
            repeat (8) @(negedge clk);
            lbo_n = k[0];
            repeat (4) @(negedge clk);
            rd(base | 20'(rnd() % 4), 4);
        end
        repeat (10) @(negedge clk);
        u_ctl.strobe(1'b1, 1'b1);
        repeat (10) @(negedge clk);
        u_ctl.strobe(1'b0, 1'b1);
        repeat (10) @(negedge clk);
        rd(base, 2);
        repeat (10) @(negedge clk);
        oe_n = 1'b1;
        u_ctl.read(base, 2, t);
        repeat (10) @(negedge clk);
        oe_n = 1'b0;
        zz = 1'b1;
        repeat (8) @(negedge clk);
        u_ctl.write(base, rw(), 1'b0, 4'h0, 1'b0);
        repeat (8) @(negedge clk);
        zz = 1'b0;
        repeat (10) @(negedge clk);
        rd(base, 4);
        repeat (20) @(negedge clk);
        report_and_stop();
    end
endmodule
